// file: hw/wave_readout_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts of the waveform readout
// Assumes: AHB-Lite word registers, byte addresses in the low eight address bits
// Notes: cycle counts are derived from times in ns and the clock rate
`ifndef WAVE_READOUT_REGS_SVH
`define WAVE_READOUT_REGS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_STATUS 8'h08
`define OFS_REPLY 8'h0C
`define OFS_SPACING 8'h10
`define OFS_TRIG_OFFSET 8'h14

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define CTRL_FMT_BIT 0
`define CTRL_PHASE_LSB 1
`define CTRL_THREE_BIT 3
`define CTRL_GEN2_BIT 4
`define CTRL_RESET 32'h0000_0000
`define TRIG_OFFSET_RESET 12'h000
`define CMD_KIND_LSB 0
`define CMD_MEAS_BIT 2
`define CMD_PARAM_BIT 3
`define CMD_COUNT_LSB 4
`define CMD_OFFSET_LSB 12
`define REPLY_VALID_BIT 8

// -----------------------------------------------------------------
// sizes and timing
// -----------------------------------------------------------------
`define CLK_MHZ 40
`define SPACING_G1_SINGLE_NS 25600
`define SPACING_G1_THREE_NS 76800
`define SPACING_G2_SINGLE_NS 10400
`define SPACING_G2_THREE_NS 31200
`define NS_TO_CYCLES(ns) (((ns) * `CLK_MHZ) / 1000)
`define BUF_SAMPLES 4096
`define BLOCK_SAMPLES 256
`define MAX_BLOCKS 16
`define ASCII_MAX_BLOCKS 8
`define PAYLOAD_MAX_BYTES 16384
`define HARM_ORDERS 51
`define HARM_MAX_ORDER 50

// -----------------------------------------------------------------
// reply characters
// -----------------------------------------------------------------
`define CHR_HASH 8'h23
`define CHR_FIVE 8'h35
`define CHR_ZERO 8'h30
`define CHR_ALPHA_BIAS 8'h37
`define CHR_COMMA 8'h2C
`define CHR_NEWLINE 8'h0A

`endif

// file: hw/wave_readout_pkg.sv
// Purpose: types shared by the waveform readout
// Assumes: nothing beyond the register header
// Notes: states are one-hot with codes written out
package wave_readout_pkg;

	// one digitized voltage/current pair, IEEE single words
	typedef struct packed {
		logic [31:0] volt;
		logic [31:0] curr;
	} sample_t;

	typedef enum logic [1:0] {
		Q_WAVE_VOLT = 2'h0,
		Q_WAVE_CURR = 2'h1,
		Q_HARM_AMP = 2'h2,
		Q_HARM_PHASE = 2'h3
	} query_kind_t;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_ACQ = 5'h02,
		S_HDR = 5'h04,
		S_DATA = 5'h08,
		S_HARM = 5'h10
	} seq_state_t;

	// harmonic result write from the computation engine
	typedef struct packed {
		logic we;
		logic is_phase;
		logic in_band;
		logic [5:0] order;
		logic [31:0] value;
	} harm_wr_t;

endpackage

// file: hw/waveform_array_readout.sv
// Purpose: waveform array capture and reply formatting behind an AHB-Lite register port
// Assumes: samples and harmonic results arrive on hclk; the trigger is an asynchronous pin
// Notes: reply bytes are popped one per read of the reply register
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`include "wave_readout_regs.svh"

// Overview of operation
// - binary format sends each sample as four bytes of its float word
// - ascii format sends each sample as eight hex characters of that word
// - format choice affects wave arrays only; harmonic replies are always ascii text
// - format selection resets to binary at every power-up
// - payload of one reply is held to at most 16384 data bytes
// - wave array replies framed as #5, five length digits, then bytes msb first
// - voltage and current captured together on measure query or trigger
// - fetch reuses the stored buffer, measure captures a fresh one first
// - first generation spacing 25.6 us single phase, 76.8 us three phase
// - second generation spacing 10.4 us single phase, 31.2 us three phase
// - spacing readable; trigger sits at the programmed offset in the buffer
// - optional block count 1 to 16 and start block 0 to 15 select data
// - without block parameters all 4096 samples are returned in binary, the first 2048 in ascii
// - harmonic arrays run dc, fundamental, then orders up to 50
// - orders beyond measurement bandwidth report zero amplitude and phase
// - phases in degrees from fundamental zero crossing; dc phase is zero
// - phase a voltage fundamental phase reports zero
// - three-phase data come from the selected output phase
module waveform_array_readout
	import wave_readout_pkg::*;
#(
	parameter int BUF_DEPTH = `BUF_SAMPLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire sample_t phase_sample [3],
	input wire harm_wr_t harm_wr,
	input wire logic acq_trigger_pin
);

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	logic take, wr_pend, pop, cmd_go, tick, trig_s1, trig_s2, trig_s3, trig_rise;
	logic [7:0] wr_addr;
	logic array_format_select, three_phase, gen2;
	logic [1:0] output_phase_select, phase_idx;
	logic [11:0] trig_offset;
	logic [31:0] sample_spacing_query, read_mux;
	logic [11:0] spacing_cyc, spacing_cnt;
	logic [11:0] wp, start_addr;
	logic [12:0] post_left;
	logic capturing, frozen, have_data, acq_done, meas_start;
	logic [31:0] volt_mem [BUF_DEPTH];
	logic [31:0] curr_mem [BUF_DEPTH];
	logic [31:0] harm_amp [`HARM_ORDERS];
	logic [31:0] harm_phase [`HARM_ORDERS];
	logic [`HARM_ORDERS-1:0] harm_in_band;
	seq_state_t state;
	query_kind_t kind;
	logic ascii;
	logic [12:0] nwords, word_idx;
	logic [3:0] char_idx;
	logic [2:0] hdr_idx;
	logic [3:0] first_block;
	logic [16:0] reply_len;
	logic [11:0] rd_addr;
	logic [31:0] cur_word, harm_word;
	logic [7:0] cur_byte, out_byte;
	logic out_valid, can_emit, emitting, last_char;

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'hA) ? (`CHR_ZERO + {4'h0, n}) : (`CHR_ALPHA_BIAS + {4'h0, n});
	endfunction

	function automatic logic [7:0] dec_char(input logic [16:0] v, input logic [2:0] pos);
		logic [16:0] q;
		q = v;
		for (int i = 0; i < 4; i++) begin
			if (i < 32'(4 - pos)) begin
				q = q / 17'd10;
			end
		end
		dec_char = `CHR_ZERO + 8'(q % 17'd10);
	endfunction

	// -----------------------------------------------------------------
	// ahb-lite slave
	// -----------------------------------------------------------------
	assign take = hsel & hready & htrans[1];
	assign pop = take & ~hwrite & (haddr[7:0] == `OFS_REPLY);

	// address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= take & hwrite;
			if (take) begin
				wr_addr <= haddr[7:0];
			end
		end
	end

	// zero-wait, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// read mux, unmapped reads return zero
	always_comb begin
		case (haddr[7:0])
			`OFS_CTRL: read_mux = {27'h0, gen2, three_phase, output_phase_select, array_format_select};
			`OFS_STATUS: read_mux = {28'h0, capturing, have_data, out_valid, state != S_IDLE};
			`OFS_REPLY: read_mux = {23'h0, out_valid, out_byte};
			`OFS_SPACING: read_mux = sample_spacing_query;
			`OFS_TRIG_OFFSET: read_mux = {20'h0, trig_offset};
			default: read_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take & ~hwrite) begin
			hrdata <= read_mux;
		end
	end

	// control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			array_format_select <= 1'(`CTRL_RESET);
			output_phase_select <= 2'h0;
			three_phase <= 1'b0;
			gen2 <= 1'b0;
			trig_offset <= `TRIG_OFFSET_RESET;
		end else if (wr_pend && wr_addr == `OFS_CTRL) begin
			array_format_select <= hwdata[`CTRL_FMT_BIT];
			output_phase_select <= hwdata[`CTRL_PHASE_LSB +: 2];
			three_phase <= hwdata[`CTRL_THREE_BIT];
			gen2 <= hwdata[`CTRL_GEN2_BIT];
		end else if (wr_pend && wr_addr == `OFS_TRIG_OFFSET) begin
			trig_offset <= hwdata[11:0];
		end
	end

	// a command written while a reply is in progress is dropped
	assign cmd_go = wr_pend & (wr_addr == `OFS_CMD) & (state == S_IDLE);

	// -----------------------------------------------------------------
	// sample spacing
	// -----------------------------------------------------------------
	// spacing by generation and phase mode
	always_comb begin
		case ({gen2, three_phase})
			2'b00: sample_spacing_query = `SPACING_G1_SINGLE_NS;
			2'b01: sample_spacing_query = `SPACING_G1_THREE_NS;
			2'b10: sample_spacing_query = `SPACING_G2_SINGLE_NS;
			default: sample_spacing_query = `SPACING_G2_THREE_NS;
		endcase
	end
	assign spacing_cyc = 12'(`NS_TO_CYCLES(sample_spacing_query));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			spacing_cnt <= 12'h000;
			tick <= 1'b0;
		end else begin
			tick <= (spacing_cnt >= spacing_cyc - 12'h001);
			spacing_cnt <= (spacing_cnt >= spacing_cyc - 12'h001) ? 12'h000 : spacing_cnt + 12'h001;
		end
	end

	// -----------------------------------------------------------------
	// trigger pin
	// -----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
		end else begin
			trig_s1 <= acq_trigger_pin;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
		end
	end
	assign trig_rise = trig_s2 & ~trig_s3;

	// -----------------------------------------------------------------
	// acquisition ring
	// -----------------------------------------------------------------
	// single phase always uses output a
	assign phase_idx = (three_phase && output_phase_select < 2'h3) ? output_phase_select : 2'h0;

	always_ff @(posedge hclk) begin
		if (tick && !frozen) begin
			volt_mem[wp] <= phase_sample[phase_idx].volt;
			curr_mem[wp] <= phase_sample[phase_idx].curr;
		end
	end

	// ring runs freely, freezes once the post-trigger part is captured
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp <= 12'h000;
			start_addr <= 12'h000;
			post_left <= 13'h0000;
			capturing <= 1'b0;
			frozen <= 1'b0;
			have_data <= 1'b0;
			acq_done <= 1'b0;
		end else begin
			acq_done <= 1'b0;
			if ((trig_rise || meas_start) && !capturing) begin
				// trigger lands at the programmed offset
				capturing <= 1'b1;
				frozen <= 1'b0;
				have_data <= 1'b0;
				post_left <= 13'(`BUF_SAMPLES) - {1'b0, trig_offset};
				start_addr <= wp - trig_offset;
			end else if (tick && !frozen) begin
				wp <= wp + 12'h001;
				if (capturing) begin
					post_left <= post_left - 13'h0001;
					if (post_left == 13'h0001) begin
						capturing <= 1'b0;
						frozen <= 1'b1;
						have_data <= 1'b1;
						acq_done <= 1'b1;
					end
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// harmonic results
	// -----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			harm_in_band <= '0;
		end else if (harm_wr.we && !harm_wr.is_phase && harm_wr.order <= 6'(`HARM_MAX_ORDER)) begin
			harm_in_band[harm_wr.order] <= harm_wr.in_band;
		end
	end

	always_ff @(posedge hclk) begin
		if (harm_wr.we && harm_wr.order <= 6'(`HARM_MAX_ORDER)) begin
			if (harm_wr.is_phase) begin
				harm_phase[harm_wr.order] <= harm_wr.value;
			end else begin
				harm_amp[harm_wr.order] <= harm_wr.value;
			end
		end
	end

	always_comb begin
		if (!harm_in_band[word_idx[5:0]]) begin
			harm_word = 32'h0000_0000;
		end else if (kind == Q_HARM_AMP) begin
			harm_word = harm_amp[word_idx[5:0]];
		end else if (word_idx == 13'h0000 || (word_idx == 13'h0001 && phase_idx == 2'h0)) begin
			harm_word = 32'h0000_0000;
		end else begin
			harm_word = harm_phase[word_idx[5:0]];
		end
	end

	// -----------------------------------------------------------------
	// reply byte formatter
	// -----------------------------------------------------------------
	assign rd_addr = start_addr + {first_block, 8'h00} + word_idx[11:0];
	assign cur_word = (kind == Q_WAVE_CURR) ? curr_mem[rd_addr] : volt_mem[rd_addr];
	assign reply_len = ascii ? {1'b0, nwords, 3'h0} : {2'h0, nwords, 2'h0};
	assign last_char = (state == S_HARM) ? (char_idx == 4'h8) : (char_idx == (ascii ? 4'h7 : 4'h3));

	always_comb begin
		cur_byte = 8'h00;
		case (state)
			S_HDR: cur_byte = (hdr_idx == 3'h0) ? `CHR_HASH : (hdr_idx == 3'h1) ? `CHR_FIVE :
				dec_char(reply_len, 3'(hdr_idx - 3'h2));
			S_DATA: begin
				if (ascii) begin
					cur_byte = hex_char(cur_word[4 * (7 - char_idx[2:0]) +: 4]);
				end else begin
					cur_byte = cur_word[8 * (3 - char_idx[1:0]) +: 8];
				end
			end
			S_HARM: begin
				// harmonic values always as ascii text
				if (char_idx == 4'h8) begin
					cur_byte = (word_idx == nwords - 13'h0001) ? `CHR_NEWLINE : `CHR_COMMA;
				end else begin
					cur_byte = hex_char(harm_word[4 * (7 - char_idx[2:0]) +: 4]);
				end
			end
			default: cur_byte = 8'h00;
		endcase
	end

	assign can_emit = ~out_valid | pop;
	assign emitting = can_emit & (state == S_HDR || state == S_DATA || state == S_HARM);

	// one-byte reply holding register, popped by reads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_valid <= 1'b0;
			out_byte <= 8'h00;
		end else if (emitting) begin
			out_valid <= 1'b1;
			out_byte <= cur_byte;
		end else if (pop) begin
			out_valid <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// command sequencer
	// -----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		logic [4:0] cnt;
		logic [4:0] room;
		logic [5:0] hcnt;
		if (!hresetn) begin
			state <= S_IDLE;
			kind <= Q_WAVE_VOLT;
			ascii <= 1'b0;
			nwords <= 13'h0000;
			word_idx <= 13'h0000;
			char_idx <= 4'h0;
			hdr_idx <= 3'h0;
			first_block <= 4'h0;
			meas_start <= 1'b0;
		end else begin
			cnt = 5'h00;
			room = 5'h00;
			hcnt = 6'h00;
			meas_start <= 1'b0;
			case (state)
				S_IDLE: begin
					if (cmd_go) begin
						kind <= query_kind_t'(hwdata[`CMD_KIND_LSB +: 2]);
						// format latched only for wave arrays
						ascii <= array_format_select & ~hwdata[1];
						word_idx <= 13'h0000;
						char_idx <= 4'h0;
						hdr_idx <= 3'h0;
						if (hwdata[1]) begin
							hcnt = hwdata[`CMD_COUNT_LSB +: 6];
							nwords <= hwdata[`CMD_PARAM_BIT] ?
								13'((hcnt > 6'(`HARM_MAX_ORDER) ? 6'(`HARM_MAX_ORDER) : hcnt) + 6'h01) :
								13'(`HARM_ORDERS);
							first_block <= 4'h0;
						end else begin
							// clamp count and offset to the buffer
							cnt = hwdata[`CMD_PARAM_BIT] ? hwdata[`CMD_COUNT_LSB +: 5] : 5'(`MAX_BLOCKS);
							room = 5'(`MAX_BLOCKS) - (hwdata[`CMD_PARAM_BIT] ? {1'b0, hwdata[`CMD_OFFSET_LSB +: 4]} : 5'h00);
							cnt = (cnt == 5'h00) ? 5'h01 : (cnt > room) ? room : cnt;
							// ascii payload capped at half the buffer
							if (array_format_select && cnt > 5'(`ASCII_MAX_BLOCKS)) begin
								cnt = 5'(`ASCII_MAX_BLOCKS);
							end
							nwords <= {cnt, 8'h00};
							first_block <= hwdata[`CMD_PARAM_BIT] ? hwdata[`CMD_OFFSET_LSB +: 4] : 4'h0;
						end
						// measure captures first, fetch reuses the buffer
						if (hwdata[`CMD_MEAS_BIT]) begin
							meas_start <= 1'b1;
							state <= S_ACQ;
						end else begin
							state <= hwdata[1] ? S_HARM : S_HDR;
						end
					end
				end
				S_ACQ: begin
					if (acq_done) begin
						state <= (kind == Q_HARM_AMP || kind == Q_HARM_PHASE) ? S_HARM : S_HDR;
					end
				end
				S_HDR: begin
					if (emitting) begin
						hdr_idx <= hdr_idx + 3'h1;
						if (hdr_idx == 3'h6) begin
							state <= S_DATA;
						end
					end
				end
				S_DATA, S_HARM: begin
					if (emitting) begin
						if (last_char) begin
							char_idx <= 4'h0;
							word_idx <= word_idx + 13'h0001;
							if (word_idx == nwords - 13'h0001) begin
								state <= S_IDLE;
							end
						end else begin
							char_idx <= char_idx + 4'h1;
						end
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

endmodule

// file: sim/wave_readout_chk.sv
// Purpose: bus-side property checks of the waveform readout
// Assumes: one slave, zero wait states, word transfers
// Notes: shadows control, offset and last command from bus writes
`timescale 1ns/100ps
`include "wave_readout_regs.svh"
module wave_readout_chk
	import wave_readout_pkg::*;
#(
	parameter int BUF_DEPTH = `BUF_SAMPLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire sample_t phase_sample [3],
	input wire harm_wr_t harm_wr,
	input wire logic acq_trigger_pin
);
	// ----
	// data phase tracking and shadows
	// ----
	logic dp_v, dp_w, fmt, fresh, ctrl_wr, rd_ok, byte_v, hx;
	logic [7:0] dp_a, c;
	logic [4:0] ctrl;
	logic [11:0] toff;
	logic [1:0] kind;
	logic [31:0] exp_sp;
	// read data phase, reply byte and character class
	assign rd_ok = dp_v & ~dp_w;
	assign byte_v = rd_ok & (dp_a == `OFS_REPLY) & hrdata[`REPLY_VALID_BIT];
	assign c = hrdata[7:0];
	assign hx = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
	assign exp_sp = ctrl[4] ? (ctrl[3] ? `SPACING_G2_THREE_NS : `SPACING_G2_SINGLE_NS)
		: (ctrl[3] ? `SPACING_G1_THREE_NS : `SPACING_G1_SINGLE_NS);
	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_v <= 1'b0;
			dp_w <= 1'b0;
			dp_a <= 8'h00;
		end else begin
			dp_v <= hsel & hready & htrans[1];
			dp_w <= hwrite;
			dp_a <= haddr[7:0];
		end
	end
	// shadows updated in write data phases
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= 5'h00;
			ctrl_wr <= 1'b0;
			toff <= 12'h000;
			kind <= 2'h0;
			fmt <= 1'b0;
			fresh <= 1'b0;
		end else begin
			if (dp_v & dp_w & (dp_a == `OFS_CTRL)) begin
				ctrl <= hwdata[4:0];
				ctrl_wr <= 1'b1;
			end
			if (dp_v & dp_w & (dp_a == `OFS_TRIG_OFFSET))
				toff <= hwdata[11:0];
			if (dp_v & dp_w & (dp_a == `OFS_CMD)) begin
				kind <= hwdata[1:0];
				fmt <= ctrl[0];
				fresh <= 1'b1;
			end else if (byte_v)
				fresh <= 1'b0;
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_spacing_first_gen: assert property (rd_ok && dp_a == `OFS_SPACING && !ctrl[4] |-> hrdata == exp_sp)
		else $error("spacing wrong for first generation");
	a_spacing_second_gen: assert property (rd_ok && dp_a == `OFS_SPACING && ctrl[4] |-> hrdata == exp_sp)
		else $error("spacing wrong for second generation");
	a_format_powerup: assert property (rd_ok && dp_a == `OFS_CTRL && !ctrl_wr |-> !hrdata[0])
		else $error("format not binary after reset");
	a_phase_select_held: assert property (rd_ok && dp_a == `OFS_CTRL |-> hrdata[4:0] == ctrl)
		else $error("control readback differs");
	a_trig_offset_held: assert property (rd_ok && dp_a == `OFS_TRIG_OFFSET |-> hrdata[11:0] == toff)
		else $error("trigger offset readback differs");
	a_frame_hash_first: assert property (byte_v && fresh && !kind[1] |-> c == `CHR_HASH)
		else $error("array reply does not open with hash");
	a_harm_text_only: assert property (byte_v && kind[1] |-> hx || c == `CHR_COMMA || c == `CHR_NEWLINE)
		else $error("harmonic reply byte not text");
	a_wave_hex_chars: assert property (byte_v && !kind[1] && fmt |-> hx || c == `CHR_HASH)
		else $error("ascii wave byte not upper hex");
	c_harm_byte: cover property (byte_v && kind[1]);
	c_ascii_wave: cover property (byte_v && !kind[1] && fmt);
	c_spacing_g2: cover property (rd_ok && dp_a == `OFS_SPACING && ctrl[4]);
endmodule

bind waveform_array_readout wave_readout_chk #(.BUF_DEPTH(BUF_DEPTH)) chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .phase_sample(phase_sample), .harm_wr(harm_wr),
	.acq_trigger_pin(acq_trigger_pin)
);

// file: sim/meas_host.sv
// Purpose: remote host model issuing queries over AHB-Lite
// Assumes: single whole-word transfers to one slave
// Notes: released address and data lines show inverted values
`timescale 1ns/100ps
module meas_host
	import wave_readout_pkg::*;
(
	input wire logic hclk,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// ----
	// bus master
	// ----
	// idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
	end
	// one transfer, each phase held until ready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~{24'h000000, a};
		hwdata <= w ? d : ~hwdata;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
		hwdata <= ~hwdata;
	endtask
	function automatic logic [31:0] half_cmd(input logic upper);
		return {16'h0000, (upper ? 4'h8 : 4'h0), 2'h0, 6'h08, 4'h8};
	endfunction
endmodule

// file: sim/waveform_array_readout_bench.sv
// Purpose: register-level tests of the waveform readout
// Assumes: host model issues single AHB-Lite transfers
// Notes: trigger offset 4095 keeps measure waits short
`timescale 1ns/100ps
`include "wave_readout_regs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module waveform_array_readout_bench
	import wave_readout_pkg::*;
;
	// ----
	// bench signals and instances
	// ----
	localparam int LIMIT = 60000;
	localparam logic [31:0] SP [4] = '{`SPACING_G1_SINGLE_NS, `SPACING_G1_THREE_NS,
		`SPACING_G2_SINGLE_NS, `SPACING_G2_THREE_NS};
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, trig;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, q, w;
	sample_t ps [3];
	harm_wr_t hw;
	int n_errors, tests_run, cyc;
	// free-running clock
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	waveform_array_readout #(.BUF_DEPTH(`BUF_SAMPLES)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .phase_sample(ps), .harm_wr(hw), .acq_trigger_pin(trig)
	);
	meas_host host (
		.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
	);
	// cycle ceiling against hangs
	always @(posedge hclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_errors++;
			complete_run();
		end
	end
	// ----
	// access tasks
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0000_0000, q);
	endtask
	// reads the reply register until a byte is valid
	task automatic pop(output logic [7:0] c);
		int k;
		k = 0;
		rd(`OFS_REPLY);
		while (q[`REPLY_VALID_BIT] !== 1'b1 && k < 3000) begin
			rd(`OFS_REPLY);
			k++;
		end
		c = q[7:0];
	endtask
	task automatic skip(input int n);
		logic [7:0] c;
		repeat (n) pop(c);
	endtask
	// block header with five length digits
	task automatic hdr(input int len);
		logic [7:0] c;
		int p;
		p = 10000;
		pop(c);
		`CHK(c, `CHR_HASH)
		pop(c);
		`CHK(c, `CHR_FIVE)
		repeat (5) begin
			pop(c);
			`CHK(c, 8'(`CHR_ZERO + (len / p) % 10))
			p = p / 10;
		end
	endtask
	function automatic logic [3:0] nib(input logic [7:0] c);
		return (c > 8'h39) ? 4'(c - 8'h37) : 4'(c - 8'h30);
	endfunction
	// one word, four bytes or eight hex characters
	task automatic word(input logic asc, output logic [31:0] v);
		logic [7:0] c;
		v = 32'h0000_0000;
		repeat (asc ? 8 : 4) begin
			pop(c);
			v = asc ? {v[27:0], nib(c)} : {v[23:0], c};
		end
	endtask
	// harmonic list: words, commas, newline last
	task automatic harm_chk(input int n, input logic ph);
		logic [7:0] c;
		logic [31:0] e;
		for (int k = 0; k < n; k++) begin
			word(1'b1, w);
			e = ph ? 32'h4000_0000 + 32'(k) : 32'h3F80_0000 + 32'(k);
			if (k == 50 || (ph && k < 2))
				e = 32'h0000_0000;
			`CHK(w, e)
			pop(c);
			`CHK(c, (k == n - 1) ? `CHR_NEWLINE : `CHR_COMMA)
		end
	endtask
	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask
	task automatic complete_run();
		$display("counts: mismatches=%0d compares=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// test sequence
	// ----
	initial begin
		trig = 1'b0;
		hw = '0;
		for (int i = 0; i < 3; i++)
			ps[i] = {32'h4120_0000 + 32'(i), 32'h3F00_0000 + 32'(i)};
		do_reset();
		// defaults, spacing table, offset, unmapped place
		rd(`OFS_CTRL);
		`CHK(q[`CTRL_FMT_BIT], 1'b0)
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_CTRL, 32'(i) << `CTRL_THREE_BIT);
			rd(`OFS_SPACING);
			`CHK(q, SP[i])
		end
		wr(`OFS_TRIG_OFFSET, 32'h0000_0FFF);
		rd(`OFS_TRIG_OFFSET);
		`CHK(q[11:0], 12'hFFF)
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40);
		`CHK(q, 32'h0000_0000)
		$display("test registers done");
		// measure on phase B, then fetch keeps the stored buffer
		wr(`OFS_CTRL, 32'h0000_001A);
		ps[1].volt <= 32'h4248_0000;
		wr(`OFS_CMD, 32'h0000_F01C);
		hdr(1024);
		skip(1020);
		word(1'b0, w);
		`CHK(w, 32'h4248_0000)
		ps[1].volt <= 32'h4296_0000;
		wr(`OFS_CMD, 32'h0000_F018);
		hdr(1024);
		skip(1020);
		word(1'b0, w);
		`CHK(w, 32'h4248_0000)
		// same block as hex text
		wr(`OFS_CTRL, 32'h0000_001B);
		wr(`OFS_CMD, 32'h0000_F018);
		hdr(2048);
		skip(2040);
		word(1'b1, w);
		`CHK(w, 32'h4248_0000)
		// trigger pin restarts the capture, fetch then sees the new sample
		trig <= 1'b1;
		repeat (1400) @(posedge hclk);
		trig <= 1'b0;
		wr(`OFS_CTRL, 32'h0000_001A);
		wr(`OFS_CMD, 32'h0000_F018);
		hdr(1024);
		skip(1020);
		word(1'b0, w);
		`CHK(w, 32'h4296_0000)
		$display("test capture done");
		// harmonic results, amplitude and phase, order 50 out of band
		for (int k = 0; k <= 50; k++) begin
			hw <= {1'b1, 1'b0, k != 50, 6'(k), 32'h3F80_0000 + 32'(k)};
			@(posedge hclk);
			hw <= {1'b1, 1'b1, 1'b1, 6'(k), 32'h4000_0000 + 32'(k)};
			@(posedge hclk);
		end
		hw <= '0;
		wr(`OFS_CTRL, 32'h0000_0010);
		wr(`OFS_CMD, 32'h0000_01EA);
		harm_chk(31, 1'b0);
		wr(`OFS_CMD, 32'h0000_0003);
		harm_chk(51, 1'b1);
		$display("test harmonics done");
		// ascii cap, reset mid reply, host half, full binary buffer
		wr(`OFS_CTRL, 32'h0000_0011);
		wr(`OFS_CMD, 32'h0000_00C8);
		hdr(16384);
		do_reset();
		rd(`OFS_CTRL);
		`CHK(q[`CTRL_FMT_BIT], 1'b0)
		rd(`OFS_REPLY);
		`CHK(q[`REPLY_VALID_BIT], 1'b0)
		wr(`OFS_CTRL, 32'h0000_0011);
		wr(`OFS_CMD, host.half_cmd(1'b1));
		hdr(16384);
		do_reset();
		wr(`OFS_CMD, 32'h0000_0000);
		hdr(16384);
		$display("test limits done");
		complete_run();
	end
endmodule
